// File: logic/prsp_core_end.sv
// receive core end: ecc protected buffer and stream sender
`timescale 1ns/100ps

// ------------------------------------------------------------
// flop based fifo with valid and ready on both sides
// ------------------------------------------------------------
module prsp_fifo #(
  parameter int W = 8,
  parameter int DEPTH = prsp_pkg::FIFO_DEPTH_DEF
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [W-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [W-1:0] outData,
  output logic [$clog2(DEPTH):0] fillCount
);
  import prsp_pkg::*;
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wrIdx_ff;
  logic [AW-1:0] rdIdx_ff;
  logic [AW:0] cnt_ff;
  logic notFull_ff;
  wire push = inValid && inReady;
  wire pop = outValid && outReady;
  wire [AW:0] nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);

  // registered so the source sees ready straight from a flop
  assign inReady = notFull_ff;
  assign outValid = (cnt_ff != '0);
  assign outData = mem_ff[rdIdx_ff];
  assign fillCount = cnt_ff;

  // wrap by compare so a non power of two depth still works
  wire [AW-1:0] nxt_wrIdx = (wrIdx_ff == AW'(DEPTH - 1)) ? '0 : wrIdx_ff + AW'(1);
  wire [AW-1:0] nxt_rdIdx = (rdIdx_ff == AW'(DEPTH - 1)) ? '0 : rdIdx_ff + AW'(1);

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_ff[wrIdx_ff] <= inData;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wrIdx_ff <= '0;
      rdIdx_ff <= '0;
      cnt_ff <= '0;
      notFull_ff <= 1'b1;
    end else begin
      if (push) wrIdx_ff <= nxt_wrIdx;
      if (pop) rdIdx_ff <= nxt_rdIdx;
      cnt_ff <= nxt_cnt;
      notFull_ff <= (nxt_cnt != (AW+1)'(DEPTH));
    end
  end
endmodule

// ------------------------------------------------------------
// core end of the receive stream
// ------------------------------------------------------------
module prsp_core_end #(
  parameter int DW = prsp_pkg::DATA_W_DEF,
  parameter int DEPTH = prsp_pkg::FIFO_DEPTH_DEF
) (
  prsp_if.core port,
  input wire logic srcValid,
  output logic srcReady,
  input wire logic [DW-1:0] srcData,
  input wire logic srcPktStart,
  input wire logic srcPktEnd,
  input wire logic [prsp_pkg::BAR_W-1:0] srcBarHit,
  input wire logic srcNonPosted,
  input wire logic srcUpperHalfEmpty,
  input wire logic eccEnable,
  input wire logic injSingleFlip,
  input wire logic injDoubleFlip
);
  import prsp_pkg::*;
  localparam int NB = DW / 8;
  localparam int CW = NB * ECC_CW_W;
  localparam int SW = CW + BAR_W + 4;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_BODY = 3'h2,
    ST_DROP = 3'h4
  } prsp_core_st_t;

  // ------------------------------------------------------------
  // secded helpers
  // ------------------------------------------------------------
  function automatic logic [ECC_CW_W-1:0] eccEncode(input logic [7:0] d);
    logic [ECC_CW_W-1:0] cw;
    int k;
    cw = '0;
    k = 0;
    for (int i = 1; i < ECC_CW_W; i++) begin
      if ((i & (i - 1)) != 0) begin
        cw[i] = d[k];
        k++;
      end
    end
    for (int p = 1; p < ECC_CW_W; p = p * 2) begin
      for (int i = 1; i < ECC_CW_W; i++) begin
        if ((i & p) != 0 && i != p) cw[p] = cw[p] ^ cw[i];
      end
    end
    cw[0] = ^cw[ECC_CW_W-1:1];
    return cw;
  endfunction

  function automatic logic [ECC_SYN_W-1:0] eccSyndrome(input logic [ECC_CW_W-1:0] cw);
    logic [ECC_SYN_W-1:0] s;
    s = '0;
    for (int i = 1; i < ECC_CW_W; i++) begin
      if (cw[i]) s = s ^ ECC_SYN_W'(i);
    end
    return s;
  endfunction

  function automatic logic [7:0] eccData(input logic [ECC_CW_W-1:0] cw);
    logic [7:0] d;
    int k;
    d = '0;
    k = 0;
    for (int i = 1; i < ECC_CW_W; i++) begin
      if ((i & (i - 1)) != 0) begin
        d[k] = cw[i];
        k++;
      end
    end
    return d;
  endfunction

  // ------------------------------------------------------------
  // write side: encode each byte, optional fault injection
  // ------------------------------------------------------------
  logic [CW-1:0] wrCode;
  logic [CW-1:0] headCode;
  logic [DW-1:0] headData;
  logic [NB-1:0] byteDouble;

  genvar b;
  generate
    for (b = 0; b < NB; b++) begin : g_byte
      wire [ECC_CW_W-1:0] rawCw = headCode[b*ECC_CW_W +: ECC_CW_W];
      wire [ECC_SYN_W-1:0] syn = eccSyndrome(rawCw);
      wire parityBad = ^rawCw;
      wire fixSingle = parityBad && (syn != '0);
      wire [ECC_CW_W-1:0] fixedCw = fixSingle ? rawCw ^ (ECC_CW_W'(1) << syn) : rawCw;
      assign wrCode[b*ECC_CW_W +: ECC_CW_W] = eccEncode(srcData[b*8 +: 8]);
      assign headData[b*8 +: 8] = eccEnable ? eccData(fixedCw) : eccData(rawCw);
      assign byteDouble[b] = !parityBad && (syn != '0);
    end
  endgenerate

  // single flip hits bit 3, double flip bits 3 and 5 of byte 0, to exercise the decoder
  localparam logic [ECC_CW_W-1:0] INJ_ONE = 13'h0008;
  localparam logic [ECC_CW_W-1:0] INJ_TWO = 13'h0028;
  wire [ECC_CW_W-1:0] injMask = injDoubleFlip ? INJ_TWO : (injSingleFlip ? INJ_ONE : '0);
  wire [CW-1:0] wrCodeInj = wrCode ^ CW'(injMask);
  wire [SW-1:0] wrWord = {srcNonPosted, srcUpperHalfEmpty, srcBarHit, srcPktEnd, srcPktStart,
    wrCodeInj};

  // ------------------------------------------------------------
  // buffer
  // ------------------------------------------------------------
  logic headValid;
  logic popNow;
  logic [SW-1:0] headWord;

  prsp_fifo #(.W(SW), .DEPTH(DEPTH)) u_buf (
    .clk_sys(port.clk_sys),
    .rst(port.rst),
    .inValid(srcValid),
    .inReady(srcReady),
    .inData(wrWord),
    .outValid(headValid),
    .outReady(popNow),
    .outData(headWord),
    .fillCount()
  );

  assign headCode = headWord[CW-1:0];
  wire headSop = headWord[CW];
  wire headEop = headWord[CW+1];
  wire [BAR_W-1:0] headBar = headWord[CW+2 +: BAR_W];
  wire headEmpty = headWord[CW+2+BAR_W];
  wire headNp = headWord[CW+3+BAR_W];

  // ------------------------------------------------------------
  // send decision
  // ------------------------------------------------------------
  prsp_core_st_t state_ff;
  logic rdyD1_ff;
  logic valid_ff;
  logic [DW-1:0] data_ff;
  logic sop_ff;
  logic eop_ff;
  logic err_ff;
  logic empty_ff;
  logic [BAR_W-1:0] bar_ff;

  wire dblErr = eccEnable && (|byteDouble);
  // posted traffic queued behind a held request waits too; no reordering here
  wire npBlock = (state_ff == ST_IDLE) && headSop && headNp && port.recvNonpostedHold;
  // ready seen one cycle back permits this cycle's send; valid follows a cycle later
  // one idle cycle after an error word keeps every cut visible
  wire canSend = rdyD1_ff && headValid && (state_ff != ST_DROP) && !npBlock && !err_ff;
  assign popNow = canSend || ((state_ff == ST_DROP) && headValid);
  wire cutShort = dblErr && !headEop;

  prsp_core_st_t nxt_state;
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (canSend) nxt_state = (headEop || dblErr) ? (cutShort ? ST_DROP : ST_IDLE) : ST_BODY;
      end
      ST_BODY: begin
        if (canSend && (headEop || dblErr)) nxt_state = cutShort ? ST_DROP : ST_IDLE;
      end
      ST_DROP: begin
        if (headValid && headEop) nxt_state = ST_IDLE;
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  wire nxt_valid = canSend;
  wire nxt_sop = canSend && headSop;
  wire nxt_eop = canSend && (headEop || dblErr);
  wire nxt_err = canSend && dblErr;
  wire [BAR_W-1:0] nxt_bar = nxt_sop ? headBar : '0;
  wire nxt_empty = (DW > 64) && canSend && headEmpty;

  always_ff @(posedge port.clk_sys or posedge port.rst) begin
    if (port.rst) begin
      state_ff <= ST_IDLE;
      rdyD1_ff <= 1'b0;
      valid_ff <= 1'b0;
      sop_ff <= 1'b0;
      eop_ff <= 1'b0;
      err_ff <= 1'b0;
      empty_ff <= 1'b0;
      bar_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      rdyD1_ff <= port.recvReady;
      valid_ff <= nxt_valid;
      sop_ff <= nxt_sop;
      eop_ff <= nxt_eop;
      err_ff <= nxt_err;
      empty_ff <= nxt_empty;
      bar_ff <= nxt_bar;
    end
  end

  always_ff @(posedge port.clk_sys or posedge port.rst) begin
    if (port.rst) begin
      data_ff <= '0;
    end else if (canSend) begin
      data_ff <= headData;
    end
  end

  // ------------------------------------------------------------
  // stream outputs
  // ------------------------------------------------------------
  // bar bits pass as decoded upstream; bit 7 reserved on endpoints
  assign port.recvValid = valid_ff;
  assign port.recvData = data_ff;
  assign port.recvPktStart = sop_ff;
  assign port.recvPktEnd = eop_ff;
  assign port.recvEccError = err_ff;
  assign port.recvUpperHalfEmpty = empty_ff;
  assign port.recvBarHit = bar_ff;
endmodule

// File: logic/prsp_pkg.sv
// constants shared by both ends of the packet receive port
package prsp_pkg;
  // ------------------------------------------------------------
  // stream geometry
  // ------------------------------------------------------------
  localparam int DATA_W_DEF = 64;
  localparam int FIFO_DEPTH_DEF = 16;
  localparam int BAR_W = 8;
  localparam int READY_LATENCY = 2;
  // ------------------------------------------------------------
  // bar hit bit positions, endpoint operation
  // ------------------------------------------------------------
  localparam int BAR_EXP_ROM_BIT = 6;
  localparam int BAR_RSVD_BIT = 7;
  // ------------------------------------------------------------
  // bar hit bit positions, root port operation
  // ------------------------------------------------------------
  localparam int RP_PRIMARY_BUS_BIT = 2;
  localparam int RP_SECONDARY_BUS_BIT = 3;
  localparam int RP_BUS_WINDOW_BIT = 4;
  localparam int RP_IO_WINDOW_BIT = 5;
  localparam int RP_NONPREF_WINDOW_BIT = 6;
  localparam int RP_PREF_WINDOW_BIT = 7;
  // ------------------------------------------------------------
  // non-posted requests still delivered after hold rises
  // ------------------------------------------------------------
  localparam int NP_AFTER_HOLD_64 = 14;
  localparam int NP_AFTER_HOLD_128 = 26;
  // ------------------------------------------------------------
  // per-byte secded code: overall parity at bit 0, hamming 1..12
  // ------------------------------------------------------------
  localparam int ECC_CW_W = 13;
  localparam int ECC_SYN_W = 4;
  // ------------------------------------------------------------
  // application side free-slot margin for ready
  // ------------------------------------------------------------
  localparam int APP_RDY_MARGIN = READY_LATENCY + 2;
endpackage

// File: logic/prsp_if.sv
// stream interface between the receive core and the application
`timescale 1ns/100ps
interface prsp_if #(
  parameter int DW = prsp_pkg::DATA_W_DEF
) (
  input wire logic clk_sys,
  input wire logic rst
);
  logic recvValid;
  logic [DW-1:0] recvData;
  logic recvPktStart;
  logic recvPktEnd;
  logic recvEccError;
  logic recvUpperHalfEmpty;
  logic [prsp_pkg::BAR_W-1:0] recvBarHit;
  logic recvReady;
  logic recvNonpostedHold;

  modport core (
    input clk_sys,
    input rst,
    output recvValid,
    output recvData,
    output recvPktStart,
    output recvPktEnd,
    output recvEccError,
    output recvUpperHalfEmpty,
    output recvBarHit,
    input recvReady,
    input recvNonpostedHold
  );

  modport app (
    input clk_sys,
    input rst,
    input recvValid,
    input recvData,
    input recvPktStart,
    input recvPktEnd,
    input recvEccError,
    input recvUpperHalfEmpty,
    input recvBarHit,
    output recvReady,
    output recvNonpostedHold
  );
endinterface

// File: logic/prsp_app_end.sv
// application end: absorbs the stream and hands words to the user
`timescale 1ns/100ps
module prsp_app_end #(
  parameter int DW = prsp_pkg::DATA_W_DEF,
  parameter int DEPTH = prsp_pkg::FIFO_DEPTH_DEF
) (
  prsp_if.app port,
  input wire logic userHoldNp,
  input wire logic userReady,
  output logic userValid,
  output logic [DW-1:0] userData,
  output logic userPktStart,
  output logic userPktEnd,
  output logic userEccError,
  output logic userUpperHalfEmpty,
  output logic [prsp_pkg::BAR_W-1:0] userBarHit,
  output logic userEccFatal
);
  import prsp_pkg::*;
  localparam int SW = DW + BAR_W + 4;
  localparam int CNTW = $clog2(DEPTH) + 1;

  // ------------------------------------------------------------
  // landing buffer
  // ------------------------------------------------------------
  logic bufValid;
  logic bufPop;
  logic [SW-1:0] bufWord;
  logic [CNTW-1:0] fill;
  // words flying under the two cycle latency need room already reserved
  wire [CNTW-1:0] freeSlots = CNTW'(DEPTH) - fill;
  wire nxt_ready = (freeSlots > CNTW'(APP_RDY_MARGIN));
  wire [SW-1:0] inWord = {port.recvEccError, port.recvUpperHalfEmpty, port.recvBarHit,
    port.recvPktEnd, port.recvPktStart, port.recvData};

  prsp_fifo #(.W(SW), .DEPTH(DEPTH)) u_land (
    .clk_sys(port.clk_sys),
    .rst(port.rst),
    .inValid(port.recvValid),
    .inReady(),
    .inData(inWord),
    .outValid(bufValid),
    .outReady(bufPop),
    .outData(bufWord),
    .fillCount(fill)
  );

  // ------------------------------------------------------------
  // user output stage
  // ------------------------------------------------------------
  logic rdy_ff;
  logic hold_ff;
  logic outValid_ff;
  logic [SW-1:0] out_ff;
  logic fatal_ff;

  assign bufPop = bufValid && (!outValid_ff || userReady);
  wire fatalSeen = port.recvValid && port.recvEccError;

  always_ff @(posedge port.clk_sys or posedge port.rst) begin
    if (port.rst) begin
      rdy_ff <= 1'b0;
      hold_ff <= 1'b0;
      outValid_ff <= 1'b0;
      out_ff <= '0;
      fatal_ff <= 1'b0;
    end else begin
      rdy_ff <= nxt_ready;
      hold_ff <= userHoldNp;
      if (bufPop) out_ff <= bufWord;
      if (bufPop) outValid_ff <= 1'b1;
      else if (userReady) outValid_ff <= 1'b0;
      if (fatalSeen) fatal_ff <= 1'b1;
    end
  end

  // sticky until reset: a double error leaves the core suspect
  assign port.recvReady = rdy_ff;
  assign port.recvNonpostedHold = hold_ff;
  assign userValid = outValid_ff;
  assign userData = out_ff[DW-1:0];
  assign userPktStart = out_ff[DW];
  assign userPktEnd = out_ff[DW+1];
  assign userBarHit = out_ff[DW+2 +: BAR_W];
  assign userUpperHalfEmpty = out_ff[DW+2+BAR_W];
  assign userEccError = out_ff[DW+3+BAR_W];
  assign userEccFatal = fatal_ff;
endmodule

// File: verif/prsp_chk.sv
// stream checks on the interface between the core end and the application end
`timescale 1ns/100ps
module prsp_chk #(
  parameter int DW = prsp_pkg::DATA_W_DEF
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic recvValid,
  input wire logic [DW-1:0] recvData,
  input wire logic recvPktStart,
  input wire logic recvPktEnd,
  input wire logic recvEccError,
  input wire logic recvUpperHalfEmpty,
  input wire logic [prsp_pkg::BAR_W-1:0] recvBarHit,
  input wire logic recvReady,
  input wire logic recvNonpostedHold
);
  import prsp_pkg::*;
  // ------------------------------------------------------------
  // packet tracking
  // ------------------------------------------------------------
  logic inPkt_ff;
  logic nxt_inPkt;
  logic startSeen;
  logic endSeen;
  assign startSeen = recvValid && recvPktStart;
  assign endSeen = recvValid && recvPktEnd;
  assign nxt_inPkt = startSeen ? !recvPktEnd : (endSeen ? 1'b0 : inPkt_ff);
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      inPkt_ff <= 1'b0;
    end else begin
      inPkt_ff <= nxt_inPkt;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  a_valid_needs_ready: assert property (
    recvValid |-> $past(recvReady, 2)) else $error("valid without ready two cycles before");
  a_valid_drop_ready: assert property (
    $fell(recvReady) |-> ##[1:2] !recvValid) else $error("valid kept after ready fell");
  a_err_with_valid: assert property (
    recvEccError |-> recvValid) else $error("ecc error outside a transfer");
  a_err_cuts_packet: assert property (
    recvValid && recvEccError |-> recvPktEnd ##1 !recvValid) else $error("error word not cut");
  a_start_with_valid: assert property (
    recvPktStart |-> recvValid) else $error("start marker without valid");
  a_end_with_valid: assert property (
    recvPktEnd |-> recvValid) else $error("end marker without valid");
  a_start_not_inside: assert property (
    startSeen |-> !inPkt_ff) else $error("new start inside a packet");
  a_word_in_packet: assert property (
    recvValid && !recvPktStart |-> inPkt_ff) else $error("word outside any packet");
  a_bar_off_start: assert property (
    !startSeen |-> recvBarHit == '0) else $error("bar hit off the start cycle");
  a_upper_empty_narrow: assert property (
    DW == 64 |-> !recvUpperHalfEmpty) else $error("upper half empty on narrow bus");
endmodule

// File: verif/tb_pcie_rx_tlp_stream_port.sv
// self-checking bench: core end and application end joined by the stream interface
`timescale 1ns/100ps
module tb_pcie_rx_tlp_stream_port;
  import prsp_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic srcValid = 1'b0;
  logic [63:0] srcData = 64'h0;
  logic srcPktStart = 1'b0;
  logic srcPktEnd = 1'b0;
  logic [7:0] srcBarHit = 8'h00;
  logic srcNonPosted = 1'b0;
  logic srcUpperHalfEmpty = 1'b0;
  logic eccEnable = 1'b1;
  logic injSingleFlip = 1'b0;
  logic injDoubleFlip = 1'b0;
  logic userHoldNp = 1'b0;
  logic userReady = 1'b1;
  logic srcReady, userValid, userPktStart, userPktEnd, userEccError, userUpperHalfEmpty;
  logic userEccFatal;
  logic [63:0] userData;
  logic [7:0] userBarHit;
  int error_cnt = 0;
  int check_count = 0;
  logic [75:0] expQ[$];
  // ------------------------------------------------------------
  // ordinary cases: one packet per row
  // ------------------------------------------------------------
  int rowLen [8] = '{1, 2, 3, 4, 1, 2, 5, 1};
  logic [7:0] rowBar [8] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h00};
  int rowSingle [8] = '{-1, 0, 1, -1, 0, -1, 4, -1};

  initial begin
    forever #5 clk_sys = ~clk_sys;
  end

  prsp_if #(.DW(64)) u_prsp_if (.clk_sys(clk_sys), .rst(rst));
  prsp_core_end #(.DW(64), .DEPTH(FIFO_DEPTH_DEF)) u_prsp_core_end (.port(u_prsp_if),
    .srcValid(srcValid), .srcReady(srcReady), .srcData(srcData), .srcPktStart(srcPktStart),
    .srcPktEnd(srcPktEnd), .srcBarHit(srcBarHit), .srcNonPosted(srcNonPosted),
    .srcUpperHalfEmpty(srcUpperHalfEmpty), .eccEnable(eccEnable),
    .injSingleFlip(injSingleFlip), .injDoubleFlip(injDoubleFlip));
  prsp_app_end #(.DW(64), .DEPTH(FIFO_DEPTH_DEF)) u_prsp_app_end (.port(u_prsp_if),
    .userHoldNp(userHoldNp), .userReady(userReady), .userValid(userValid),
    .userData(userData), .userPktStart(userPktStart), .userPktEnd(userPktEnd),
    .userEccError(userEccError), .userUpperHalfEmpty(userUpperHalfEmpty),
    .userBarHit(userBarHit), .userEccFatal(userEccFatal));
  prsp_chk #(.DW(64)) u_prsp_chk (.clk_sys(clk_sys), .rst(rst),
    .recvValid(u_prsp_if.recvValid), .recvData(u_prsp_if.recvData),
    .recvPktStart(u_prsp_if.recvPktStart), .recvPktEnd(u_prsp_if.recvPktEnd),
    .recvEccError(u_prsp_if.recvEccError), .recvUpperHalfEmpty(u_prsp_if.recvUpperHalfEmpty),
    .recvBarHit(u_prsp_if.recvBarHit), .recvReady(u_prsp_if.recvReady),
    .recvNonpostedHold(u_prsp_if.recvNonpostedHold));

  task automatic check_val(input logic [75:0] seen, input logic [75:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks=%0d errors=%0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // holds the word until the buffer takes it; bounded so a full buffer cannot hang
  task automatic push(input logic [63:0] d, input logic s, input logic e, input logic [7:0] b,
                      input logic np, input logic i1, input logic i2);
    int n;
    srcValid = 1'b1;
    srcData = d;
    srcPktStart = s;
    srcPktEnd = e;
    srcBarHit = b;
    srcNonPosted = np;
    injSingleFlip = i1;
    injDoubleFlip = i2;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (srcReady !== 1'b1 && n < 2000);
    #1;
    if (n >= 2000) begin
      error_cnt++;
      give_verdict();
    end
  endtask

  // with correction on, words after a double error are dropped, so they are not expected
  task automatic pkt(input logic [63:0] base, input int len, input logic [7:0] b,
                     input logic np, input int sIdx, input int dIdx);
    logic [63:0] d;
    logic hit;
    for (int i = 0; i < len; i++) begin
      d = base + 64'(i);
      hit = eccEnable && (i == dIdx);
      // a double flip lands on data bits 0 and 1 of byte 0
      if (!eccEnable || dIdx < 0 || i <= dIdx) begin
        expQ.push_back({1'b0, hit, i == 0, (i == len - 1) || hit,
                        (i == 0) ? b : 8'h00, d ^ ((i == dIdx) ? 64'h3 : 64'h0)});
      end
      push(d, i == 0, i == len - 1, b, np, i == sIdx, i == dIdx);
    end
    srcValid = 1'b0;
    tick(1);
  endtask

  task automatic drain();
    int n;
    n = 0;
    while (expQ.size() != 0 && n < 3000) begin
      tick(1);
      n++;
    end
    if (n >= 3000) begin
      error_cnt++;
      give_verdict();
    end
    tick(4);
  endtask

  // ------------------------------------------------------------
  // user side scoreboard
  // ------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (rst === 1'b0 && userValid === 1'b1 && userReady === 1'b1) begin
      if (expQ.size() == 0) begin
        check_val(76'h1, 76'h0);
      end else begin
        check_val({userUpperHalfEmpty, userEccError, userPktStart, userPktEnd, userBarHit,
                   userData}, expQ.pop_front());
      end
    end
  end

  initial begin
    tick(2);
    rst = 1'b0;
    check_val(76'({srcReady, userValid, userEccFatal}), 76'h4);
    for (int r = 0; r < 8; r++) begin
      srcUpperHalfEmpty = r[0];
      pkt(64'h5A00_0000_0000_0000 + 64'(r * 256), rowLen[r], rowBar[r], 1'b0, rowSingle[r], -1);
    end
    drain();
    // error output stays low with correction off
    eccEnable = 1'b0;
    pkt(64'h0E0E_0000_0000_0000, 2, 8'h01, 1'b0, -1, 0);
    drain();
    eccEnable = 1'b1;
    // double error in mid-packet, then a clean packet behind it
    check_val(76'(userEccFatal), 76'h0);
    pkt(64'hDEAD_0000_0000_0000, 3, 8'h04, 1'b0, -1, 1);
    pkt(64'hBEEF_0000_0000_0000, 2, 8'h08, 1'b0, -1, -1);
    drain();
    check_val(76'(userEccFatal), 76'h1);
    // hold: a delivered request survives, a new one waits
    userReady = 1'b0;
    pkt(64'hAAAA_0000_0000_0000, 1, 8'h01, 1'b1, -1, -1);
    tick(10);
    userHoldNp = 1'b1;
    pkt(64'hBBBB_0000_0000_0000, 1, 8'h02, 1'b1, -1, -1);
    tick(20);
    userReady = 1'b1;
    tick(20);
    check_val(76'(expQ.size()), 76'h1);
    userHoldNp = 1'b0;
    drain();
    // fill both buffers until refused, then drain with stalls
    userReady = 1'b0;
    fork
      pkt(64'hF000_0000_0000_0000, 40, 8'h10, 1'b0, -1, -1);
    join_none
    tick(100);
    check_val(76'(srcReady), 76'h0);
    for (int n = 0; n < 150; n++) begin
      userReady = (n % 3) != 0;
      tick(1);
    end
    userReady = 1'b1;
    drain();
    // second reset in mid-run clears the sticky flag
    rst = 1'b1;
    tick(1);
    check_val(76'({srcReady, userValid, userEccFatal}), 76'h4);
    rst = 1'b0;
    tick(2);
    pkt(64'h1234_0000_0000_0000, 2, 8'h20, 1'b0, -1, -1);
    drain();
    give_verdict();
  end
endmodule
